// ---- shared/swdiag_pkg.sv ----
// Constants shared by both ends of the switch diagnosis serial link.
package swdiag_pkg;

  // Word layout.
  localparam int CHANNELS   = 8;
  localparam int MODE_BITS  = 2;
  localparam int WORD_BITS  = 16;
  localparam int OPEN_POS   = 1;
  localparam int TRIP_POS   = 0;

  // Channel mode encodings.
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_INPUT   = 2'h1;
  localparam logic [1:0] MODE_ON      = 2'h2;
  localparam logic [1:0] MODE_OFF     = 2'h3;

  // Reset values.
  localparam logic [15:0] INPUT_RESET = 16'hffff;
  localparam logic        FAULT_RESET = 1'b1;

  // Frame length check.
  localparam int FRAME_STEP = 8;
  localparam int FRAME_MIN  = 16;
  localparam logic [1:0] MIN_OCTETS = 2'(FRAME_MIN / FRAME_STEP);

  // Timing, core clock at 20 MHz.
  localparam int CORE_CLK_NS = 50;
  localparam int OPEN_OUTPUT_DELAY_MIN_NS = 30000;
  localparam int OPEN_OUTPUT_DELAY_MAX_NS = 200000;
  localparam int OVERCURRENT_SHUTDOWN_DELAY_MIN_NS = 3000;
  localparam int OVERCURRENT_SHUTDOWN_DELAY_MAX_NS = 50000;
  // The shortest legal delay, rounded up to whole cycles.
  localparam int OPEN_OUTPUT_CYCLES =
    (OPEN_OUTPUT_DELAY_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int OVERCURRENT_CYCLES =
    (OVERCURRENT_SHUTDOWN_DELAY_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // Host serial clock half period in core cycles.
  localparam int HOST_HALF_CYCLES = 4;
  localparam int HOST_HALF_MIN    = 3;

endpackage

// ---- shared/swdiag_link_if.sv ----
// Four-wire serial link between the host master and the switch device.
`timescale 1ns/1ns
interface swdiag_link_if;
  logic sclk;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic so_wire;

  // Released line reads low, as the pull-down on the master side.
  assign so_wire = so_oe ? so : 1'b0;

  modport device (
    input  sclk,
    input  cs_n,
    input  si,
    output so,
    output so_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output si,
    input  so_wire
  );
endinterface

// ---- rtl/persist_timer.sv ----
// Persistence timer: fires once a condition has held for CYCLES cycles.
`timescale 1ns/1ns
module persist_timer
  import swdiag_pkg::*;
#(
  parameter int CYCLES = 60
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Condition and result
  input  wire logic cond,
  output logic      fired
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin
    $error("persist_timer needs CYCLES of at least one");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          fired;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (!cond) begin
      state_next.cnt   = '0;
      state_next.fired = 1'b0;
    end else if (state_reg.cnt == CW'(CYCLES - 1)) begin
      state_next.fired = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fired = state_reg.fired;
endmodule

// ---- rtl/switch_diag_device.sv ----
// Switch device end: serial slave, channel modes and latched diagnosis.
// Function
// [RULE1] Latch protection trip per channel until cleared.
// [RULE2] Latch open-output flag per channel separately.
// [RULE3] Only a standby write clears both flags.
// [RULE4] Open detection only when off, after delay.
// [RULE5] Overtemperature sets trip, forces channel off.
// [RULE6] Overload switches off after delay, sets trip.
// [RULE7] Master frames each access with select low.
// [RULE8] Sample input falling, advance output rising.
// [RULE9] Both streams carry most significant bit first.
// [RULE10] Select high: ignore clock, release output.
// [RULE11] Select falling loads flags for transmission.
// [RULE12] Before first rise, output is fault OR input.
// [RULE13] Any reset sets the transfer fault flag.
// [RULE14] Accept word only at multiples of eight, sixteen+.
// [RULE15] Master keeps clock low at select edges.
// [RULE16] One bit per clock; sixteen pass a word.
// [RULE17] Chain master shifts sum of all lengths.
// [RULE18] Mode codes: standby, input, on, off.
// [RULE19] Reset sets all mode bits to one.
// [RULE20] Open flags odd bits, trip flags even.
// [RULE21] Good frame clears fault flag; bad keeps it. Code sets it on every bad frame.
// [RULE22] Clock count restarts at each select fall.
`timescale 1ns/1ns
module switch_diag_device
  import swdiag_pkg::*;
(
  // Core clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Link clocked by the master's serial clock
  swdiag_link_if.device            link,
  // Channel pins and protection sensors, asynchronous
  input  wire logic [CHANNELS-1:0] input_pin,
  input  wire logic [CHANNELS-1:0] over_temp,
  input  wire logic [CHANNELS-1:0] over_load,
  input  wire logic [CHANNELS-1:0] open_sense,
  // Power stage control
  output logic [CHANNELS-1:0]      channel_on,
  output logic [CHANNELS-1:0]      diag_current_en,
  output logic                     sleep,
  // Diagnosis view
  output logic [CHANNELS-1:0]      protection_trip_flag,
  output logic [CHANNELS-1:0]      open_output_flag,
  output logic                     transfer_fault_flag
);

  typedef struct packed {
    logic [3:0][CHANNELS-1:0] sense_s1;
    logic [3:0][CHANNELS-1:0] sense_s2;
    logic                 cs_s1;
    logic                 cs_s2;
    logic                 wr_s1;
    logic                 wr_s2;
    logic                 wr_s3;
    logic [WORD_BITS-1:0] mode;
    logic [CHANNELS-1:0]  trip;
    logic [CHANNELS-1:0]  open;
    logic [WORD_BITS-1:0] snap;
    logic [CHANNELS-1:0]  on;
    logic [CHANNELS-1:0]  diag_en;
    logic                 sleep;
  } core_state_t;

  core_state_t core_reg;
  core_state_t core_next;

  // Link-side state, one group of flip-flops per link edge.
  logic                 frame_tag_reg;
  logic                 rise_tag_reg;
  logic                 fall_tag_reg;
  logic                 so_reg;
  logic [WORD_BITS-1:0] shift_reg;
  logic [2:0]           bit_cnt_reg;
  logic [1:0]           octet_cnt_reg;
  logic [WORD_BITS-1:0] input_reg;
  logic                 write_tgl_reg;
  logic                 fault_reg;

  logic                 first_rise;
  logic                 first_fall;
  logic                 frame_ok;
  logic [WORD_BITS-1:0] shift_src;
  logic [CHANNELS-1:0]  ovl_fired;
  logic [CHANNELS-1:0]  open_fired;
  logic [CHANNELS-1:0]  ovl_cond;
  logic [CHANNELS-1:0]  open_cond;

  function automatic logic [1:0] mode_of(input logic [WORD_BITS-1:0] w,
                                         input int ch);
    // [RULE18] mode field select
    mode_of = w[MODE_BITS*ch +: MODE_BITS];
  endfunction

  function automatic logic [WORD_BITS-1:0] diag_word(
    input logic [CHANNELS-1:0] open_f,
    input logic [CHANNELS-1:0] trip_f);
    logic [WORD_BITS-1:0] w;
    w = '0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      // [RULE20] flag placement
      w[MODE_BITS*ch + OPEN_POS] = open_f[ch];
      w[MODE_BITS*ch + TRIP_POS] = trip_f[ch];
    end
    diag_word = w;
  endfunction

  // A frame owns the link from select falling; each clock edge compares
  // its own tag with the frame tag to know whether it is the first one.
  always_ff @(negedge link.cs_n or posedge rst) begin
    if (rst) begin
      frame_tag_reg <= 1'b0;
    end else begin
      // [RULE22] new frame tag
      frame_tag_reg <= ~frame_tag_reg;
    end
  end

  assign first_rise = rise_tag_reg != frame_tag_reg;
  assign first_fall = fall_tag_reg != frame_tag_reg;
  // [RULE11] flags enter the shift path
  assign shift_src = first_fall ? core_reg.snap : shift_reg;
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      rise_tag_reg <= 1'b0;
      so_reg       <= 1'b0;
    end else if (!link.cs_n) begin
      // [RULE8] output advances on rise
      rise_tag_reg <= frame_tag_reg;
      // [RULE9] most significant first
      so_reg       <= first_rise ? core_reg.snap[WORD_BITS-1]
                                 : shift_reg[WORD_BITS-1];
    end
  end

  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      fall_tag_reg  <= 1'b0;
      shift_reg     <= '0;
      bit_cnt_reg   <= '0;
      octet_cnt_reg <= '0;
    end else if (!link.cs_n) begin
      fall_tag_reg <= frame_tag_reg;
      // [RULE16] one bit in per clock
      shift_reg    <= {shift_src[WORD_BITS-2:0], link.si};
      // [RULE22] count restarts each frame
      if (first_fall) begin
        bit_cnt_reg   <= 3'h1;
        octet_cnt_reg <= 2'h0;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7 && octet_cnt_reg != MIN_OCTETS) begin
          octet_cnt_reg <= octet_cnt_reg + 2'h1;
        end
      end
    end
  end

  // [RULE14] length check at select rise
  assign frame_ok = !first_fall && bit_cnt_reg == 3'h0 &&
                    octet_cnt_reg == MIN_OCTETS;
  always_ff @(posedge link.cs_n or posedge rst) begin
    if (rst) begin
      // [RULE19] all modes forced off
      input_reg     <= INPUT_RESET;
      write_tgl_reg <= 1'b0;
      // [RULE13] reset reports a fault
      fault_reg     <= FAULT_RESET;
    end else if (frame_ok) begin
      input_reg     <= shift_reg;
      write_tgl_reg <= ~write_tgl_reg;
      // [RULE21] good frame clears fault
      fault_reg     <= 1'b0;
    end else begin
      fault_reg     <= 1'b1;
    end
  end

  // [RULE12] fault OR input before first rise
  // [RULE10] released while select is high
  assign link.so    = first_rise ? (fault_reg | link.si) : so_reg;
  assign link.so_oe = !link.cs_n;
  // Overload and open-output filters, one pair per channel.
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    persist_timer #(
      .CYCLES(OVERCURRENT_CYCLES)
    ) u_ovl (
      .core_clk(core_clk),
      .rst     (rst),
      .cond    (ovl_cond[ch]),
      .fired   (ovl_fired[ch])
    );
    persist_timer #(
      .CYCLES(OPEN_OUTPUT_CYCLES)
    ) u_open (
      .core_clk(core_clk),
      .rst     (rst),
      .cond    (open_cond[ch]),
      .fired   (open_fired[ch])
    );
  end

  always_comb begin
    logic [1:0]          m;
    logic                want;
    logic                clr;
    logic [CHANNELS-1:0] standby;
    m         = MODE_STANDBY;
    want      = 1'b0;
    clr       = 1'b0;
    standby   = '0;
    ovl_cond  = '0;
    open_cond = '0;
    core_next = core_reg;
    core_next.sense_s1 = {open_sense, over_load, over_temp, input_pin};
    core_next.sense_s2 = core_reg.sense_s1;
    core_next.cs_s1   = link.cs_n;
    core_next.cs_s2   = core_reg.cs_s1;
    core_next.wr_s1   = write_tgl_reg;
    core_next.wr_s2   = core_reg.wr_s1;
    core_next.wr_s3   = core_reg.wr_s2;
    // The input word is stable for a whole frame after its toggle moves.
    if (core_reg.wr_s2 != core_reg.wr_s3) begin
      core_next.mode = input_reg;
    end
    for (int ch = 0; ch < CHANNELS; ch++) begin
      m    = mode_of(core_reg.mode, ch);
      want = m == MODE_ON || (m == MODE_INPUT && core_reg.sense_s2[0][ch]);
      // [RULE3] standby write clears flags
      clr  = core_reg.wr_s2 != core_reg.wr_s3 &&
             mode_of(input_reg, ch) == MODE_STANDBY;
      standby[ch] = m == MODE_STANDBY;
      // [RULE6] overload filter while on
      ovl_cond[ch] = core_reg.on[ch] && core_reg.sense_s2[2][ch];
      // [RULE4] open detection only when off
      open_cond[ch] = !core_reg.on[ch] && !standby[ch] &&
                      core_reg.sense_s2[3][ch];
      // [RULE1] trip latch, set beats clear
      // [RULE5] overtemperature sets trip
      core_next.trip[ch] = (core_reg.trip[ch] && !clr) ||
                           core_reg.sense_s2[1][ch] || ovl_fired[ch];
      // [RULE2] open latch, set beats clear
      core_next.open[ch] = (core_reg.open[ch] && !clr) || open_fired[ch];
      // [RULE5] tripped channel held off
      core_next.on[ch] = want && !core_next.trip[ch];
      core_next.diag_en[ch] = !standby[ch] && !core_next.on[ch];
    end
    core_next.sleep = &standby;
    // Snapshot freezes once select low is seen; the master must allow
    // three core cycles from select falling to the first clock edge.
    if (core_reg.cs_s2) begin
      core_next.snap = diag_word(core_reg.open, core_reg.trip);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_reg       <= '0;
      core_reg.cs_s1 <= 1'b1;
      core_reg.cs_s2 <= 1'b1;
      core_reg.mode  <= INPUT_RESET;
      core_reg.diag_en <= '1;
    end else begin
      core_reg <= core_next;
    end
  end
  assign channel_on           = core_reg.on;
  assign diag_current_en      = core_reg.diag_en;
  assign sleep                = core_reg.sleep;
  assign protection_trip_flag = core_reg.trip;
  assign open_output_flag     = core_reg.open;
  assign transfer_fault_flag  = fault_reg;
endmodule

// ---- rtl/switch_diag_host.sv ----
// Host end: serial master that frames, clocks and collects one word.
`timescale 1ns/1ns
module switch_diag_host
  import swdiag_pkg::*;
#(
  parameter int FRAME_BITS = WORD_BITS,
  parameter int HALF       = HOST_HALF_CYCLES
) (
  // Core clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Link, serial clock made here
  swdiag_link_if.host                link,
  // User request
  input  wire logic                  start,
  input  wire logic [FRAME_BITS-1:0] tx_word,
  // User answer
  output logic                       busy,
  output logic                       done,
  output logic [FRAME_BITS-1:0]      rx_word,
  output logic                       rx_fault
);
  localparam int BW = $clog2(FRAME_BITS + 1);
  localparam int HW = $clog2(HALF + 1);

  if (FRAME_BITS < 2 || HALF < HOST_HALF_MIN) begin
    $error("switch_diag_host needs FRAME_BITS >= 2 and HALF >= 3");
  end

  typedef enum logic [2:0] {IDLE, LEAD, HIGH, LOW, TRAIL, GAP} phase_t;

  typedef struct packed {
    phase_t                phase;
    logic [HW-1:0]         tick;
    logic [BW-1:0]         bits;
    logic [FRAME_BITS-1:0] tx_sh;
    logic [FRAME_BITS-1:0] rx_sh;
    logic [FRAME_BITS-1:0] rx_word;
    logic                  fault;
    logic                  done;
    logic                  sclk;
    logic                  cs_n;
    logic                  si;
    logic                  so_s1;
    logic                  so_s2;
  } host_state_t;

  host_state_t st_reg;
  host_state_t st_next;
  logic        tick_end;

  assign tick_end = st_reg.tick == HW'(HALF - 1);

  always_comb begin
    st_next       = st_reg;
    st_next.done  = 1'b0;
    st_next.so_s1 = link.so_wire;
    st_next.so_s2 = st_reg.so_s1;
    st_next.tick  = tick_end ? '0 : st_reg.tick + HW'(1);
    case (st_reg.phase)
      IDLE: begin
        st_next.tick = '0;
        // [RULE7] select low opens the access
        if (start) begin
          st_next.cs_n  = 1'b0;
          st_next.tx_sh = tx_word;
          st_next.si    = tx_word[FRAME_BITS-1];
          st_next.bits  = '0;
          st_next.phase = LEAD;
        end
      end
      LEAD: begin
        if (tick_end) begin
          // [RULE12] fault seen before the first rise
          st_next.fault = st_reg.so_s2;
          st_next.sclk  = 1'b1;
          st_next.phase = HIGH;
        end
      end
      HIGH: begin
        if (tick_end) begin
          st_next.sclk  = 1'b0;
          // [RULE9] most significant first
          st_next.rx_sh = {st_reg.rx_sh[FRAME_BITS-2:0], st_reg.so_s2};
          st_next.bits  = st_reg.bits + BW'(1);
          // [RULE17] exactly the chain length
          st_next.phase = st_reg.bits == BW'(FRAME_BITS - 1) ? TRAIL : LOW;
        end
      end
      LOW: begin
        if (tick_end) begin
          st_next.sclk  = 1'b1;
          st_next.tx_sh = st_reg.tx_sh << 1;
          st_next.si    = st_reg.tx_sh[FRAME_BITS-2];
          st_next.phase = HIGH;
        end
      end
      TRAIL: begin
        // [RULE15] clock stays low at select rise
        if (tick_end) begin
          st_next.cs_n    = 1'b1;
          st_next.done    = 1'b1;
          st_next.rx_word = st_reg.rx_sh;
          st_next.phase   = GAP;
        end
      end
      GAP: begin
        if (tick_end) begin
          st_next.phase = IDLE;
        end
      end
      default: begin
        st_next.phase = IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg       <= '0;
      st_reg.phase <= IDLE;
      st_reg.cs_n  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.sclk = st_reg.sclk;
  assign link.cs_n = st_reg.cs_n;
  assign link.si   = st_reg.si;
  assign busy      = st_reg.phase != IDLE;
  assign done      = st_reg.done;
  assign rx_word   = st_reg.rx_word;
  assign rx_fault  = st_reg.fault;
endmodule

// ---- test/switch_diag_link_checker.sv ----
// Concurrent checks on the serial link between host and device ends.
`timescale 1ns/1ns
module switch_diag_link_checker
  import swdiag_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  typedef struct packed {
    logic       sclk_q;
    logic       seen;
    logic [5:0] rises;
  } mon_t;

  mon_t mon_reg;
  mon_t mon_next;

  // The serial clock comes from a core flop, so core edges see every rise.
  always_comb begin
    mon_next = mon_reg;
    mon_next.sclk_q = sclk;
    if (cs_n) begin
      mon_next.seen = 1'b0;
      mon_next.rises = 6'h0;
    end else if (sclk && !mon_reg.sclk_q) begin
      mon_next.seen = 1'b1;
      mon_next.rises = mon_reg.rises + 6'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mon_reg <= '0;
    end else begin
      mon_reg <= mon_next;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence quiet_start;
    !sclk [*3];
  endsequence

  sequence first_rise;
    ##[1:8] $rose(sclk);
  endsequence

  property frame_open_p;
    $fell(cs_n) |-> quiet_start ##0 first_rise;
  endproperty

  oe_release_a : assert property (cs_n |-> !so_oe)
    else $error("so driven while deselected");
  oe_drive_a : assert property (!cs_n |-> so_oe)
    else $error("so released while selected");
  pre_rise_or_a : assert property (
    (!cs_n && !sclk && !mon_reg.seen && si) |-> so)
    else $error("so not high before first rise");
  so_hold_a : assert property (
    (!cs_n && mon_reg.seen && !$rose(sclk)) |-> $stable(so))
    else $error("so moved away from a rise");
  si_hold_a : assert property (
    (!cs_n && $fell(sclk)) |-> $stable(si))
    else $error("si moved at a falling edge");
  cs_clk_low_a : assert property (
    $changed(cs_n) |-> !sclk && !$past(sclk))
    else $error("sclk high at select edge");
  idle_clk_low_a : assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  frame_open_a : assert property (frame_open_p)
    else $error("frame start order wrong");
  frame_close_a : assert property (
    $fell(cs_n) |-> ##[130:140] $rose(cs_n))
    else $error("frame not closed in time");
  frame_len_a : assert property (
    $rose(cs_n) |-> mon_reg.rises == 6'(WORD_BITS))
    else $error("wrong clock count in frame");
endmodule

// ---- test/switch_diag_spi_slave_tb_top.sv ----
// Bench: host and device joined, plus a second device driven bit by bit.
`timescale 1ns/1ns
module switch_diag_spi_slave_tb_top
  import swdiag_pkg::*;
;
  logic                core_clk = 1'b0;
  logic                rst = 1'b0;
  logic                start = 1'b0;
  logic [15:0]         tx_word = 16'h0;
  logic [CHANNELS-1:0] pin = '0, temp = '0, load = '0, sense = '0;
  logic                busy, done, rx_fault, sleep1, fault_b, first, fault1;
  logic [15:0]         rx_word;
  logic [CHANNELS-1:0] on1, dcur1, trip1, openf1, on_b;
  logic [31:0]         got;
  int                  error_cnt = 0;
  int                  total_checks = 0;

  always #25 core_clk = ~core_clk;

  swdiag_link_if lnk();
  swdiag_link_if lnk2();

  switch_diag_host u_switch_diag_host (.core_clk(core_clk), .rst(rst),
    .link(lnk.host), .start(start), .tx_word(tx_word), .busy(busy),
    .done(done), .rx_word(rx_word), .rx_fault(rx_fault));
  switch_diag_device u_switch_diag_device (.core_clk(core_clk), .rst(rst),
    .link(lnk.device), .input_pin(pin), .over_temp(temp),
    .over_load(load), .open_sense(sense), .channel_on(on1),
    .diag_current_en(dcur1), .sleep(sleep1), .protection_trip_flag(trip1),
    .open_output_flag(openf1), .transfer_fault_flag(fault1));
  switch_diag_device u_switch_diag_device_b (.core_clk(core_clk),
    .rst(rst), .link(lnk2.device), .input_pin(pin), .over_temp(temp),
    .over_load(load), .open_sense(sense), .channel_on(on_b),
    .diag_current_en(), .sleep(), .protection_trip_flag(),
    .open_output_flag(), .transfer_fault_flag(fault_b));
  switch_diag_link_checker u_switch_diag_link_checker (
    .core_clk(core_clk), .rst(rst), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe));

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string what);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic host_xfer(input logic [15:0] tx);
    int n;
    @(posedge core_clk);
    start <= 1'b1;
    tx_word <= tx;
    @(posedge core_clk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 300, 1'b1, "host done");
    chk(busy, 1'b1, "busy at done");
    // Busy drops a half period after done.
    repeat (8) @(negedge core_clk);
    chk(busy, 1'b0, "busy released");
  endtask

  // Link clock of 15 ns; si moves 1 ns after each fall to stay clear of it.
  task automatic bb_frame(input int bits, input logic [31:0] data);
    got = '0;
    @(posedge core_clk);
    lnk2.si <= data[bits-1];
    lnk2.cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    first = lnk2.so_wire;
    for (int i = bits - 1; i >= 0; i--) begin
      #1 lnk2.si = data[i];
      #7 lnk2.sclk = 1'b1;
      #7 lnk2.sclk = 1'b0;
      got = {got[30:0], lnk2.so_wire};
    end
    @(posedge core_clk);
    lnk2.cs_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  initial begin
    lnk2.sclk = 1'b0;
    lnk2.cs_n = 1'b1;
    lnk2.si = 1'b0;
    #1000000;
    error_cnt++;
    end_sim();
  end

  initial begin
    // A real rising edge, so the link-side flops see their reset too.
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    bb_frame(12, 32'h7ff);
    chk(first, 1'b1, "first frame fault");
    chk(fault_b, 1'b1, "short frame");
    bb_frame(24, 32'h43aaaa);
    chk(first, 1'b1, "fault kept");
    chk(got, 32'h000043, "pass through");
    chk(on_b, 8'hff, "long frame taken");
    chk(fault_b, 1'b0, "fault cleared");
    repeat (3) begin
      #8 lnk2.sclk = 1'b1;
      #7 lnk2.sclk = 1'b0;
    end
    bb_frame(16, 32'h7fff);
    chk(first, 1'b0, "or with si low");
    chk(on_b, 8'h00, "idle clocks ignored");
    bb_frame(16, 32'hffff);
    chk(first, 1'b1, "or with si high");
    $display("test bitbang done");
    host_xfer(16'h7fff);
    chk(rx_fault, 1'b1, "host first fault");
    chk(rx_word, 16'h0, "clean flags");
    chk(dcur1, 8'hff, "reset diag current");
    chk(on1, 8'h00, "reset all off");
    pin <= 8'h02;
    host_xfer(16'hbfe6);
    chk(rx_fault, 1'b1, "fault or si high");
    chk(fault1, 1'b0, "host fault clear");
    repeat (10) @(posedge core_clk);
    chk(on1, 8'h87, "mode codes");
    $display("test modes done");
    load <= 8'h01;
    repeat (30) @(posedge core_clk);
    chk(on1[0], 1'b1, "overload delay");
    repeat (80) @(posedge core_clk);
    chk(on1[0], 1'b0, "overload off");
    chk(trip1, 8'h01, "trip latched");
    load <= 8'h00;
    temp <= 8'h80;
    repeat (10) @(posedge core_clk);
    temp <= 8'h00;
    chk(trip1, 8'h81, "overtemp trip");
    chk(on1, 8'h06, "overtemp off");
    $display("test protection done");
    sense <= 8'h0c;
    repeat (500) @(posedge core_clk);
    chk(openf1, 8'h00, "open delay");
    repeat (200) @(posedge core_clk);
    chk(openf1, 8'h08, "open only off");
    sense <= 8'h00;
    host_xfer(16'hbfe6);
    chk(rx_word, 16'h4081, "diag word layout");
    chk(on1, 8'h06, "rewrite keeps trip");
    host_xfer(16'hbfe4);
    repeat (10) @(posedge core_clk);
    chk(trip1, 8'h80, "standby clears one");
    chk(openf1, 8'h08, "other flags kept");
    host_xfer(16'h0000);
    chk(rx_fault, 1'b0, "fault or si low");
    repeat (10) @(posedge core_clk);
    chk({trip1, openf1}, 16'h0, "standby clears all");
    chk(sleep1, 1'b1, "all standby sleep");
    host_xfer(16'hbfe6);
    repeat (10) @(posedge core_clk);
    chk(rx_word, 16'h0, "flags stay clear");
    chk(on1, 8'h87, "gate released");
    $display("test standby done");
    end_sim();
  end
endmodule
